// ---- src/sdfpm_params.svh ----
// Purpose: constants for the serial converter frame link
// Assumes: 125 MHz reference clock, 8 ns period
// Notes: times in ns, counts derived here
`ifndef SDFPM_PARAMS_SVH
`define SDFPM_PARAMS_SVH
`define SDFPM_CLK_NS 8
`define SDFPM_FRAME_BITS 16
`define SDFPM_CODE_BITS 8
`define SDFPM_MODE_MSB 15
`define SDFPM_MODE_LSB 14
`define SDFPM_CODE_MSB 13
`define SDFPM_CODE_LSB 6
`define SDFPM_CODE_RESET 8'h00
`define SDFPM_MODE_RESET 2'h0
`define SDFPM_WAKE_NS 50000
`define SDFPM_WAKE_CYC ((`SDFPM_WAKE_NS + `SDFPM_CLK_NS - 1) / `SDFPM_CLK_NS)
`define SDFPM_SEL_HIGH_NS 20
`define SDFPM_SEL_HIGH_CYC ((`SDFPM_SEL_HIGH_NS + `SDFPM_CLK_NS - 1) / `SDFPM_CLK_NS)
`define SDFPM_SCLK_HALF 8
`endif

// ---- src/sdfpm_pkg.sv ----
// Purpose: types shared by both ends of the frame link
// Assumes: nothing
// Notes: mode encoding matches the two frame mode bits
package sdfpm_pkg;
    typedef enum logic [1:0] {
        SDFPM_NORMAL = 2'h0,
        SDFPM_GND_1K = 2'h1,
        SDFPM_GND_100K = 2'h2,
        SDFPM_HIGH_Z = 2'h3
    } sdfpm_mode_t;
endpackage

// ---- src/sdfpm_if.sv ----
// Purpose: three-wire write-only link between host and converter
// Assumes: host drives all three wires
// Notes: no clocking block, bench joins the ends
`timescale 1ns/10ps
interface sdfpm_if;
    logic frame_sel_n;
    logic sclk;
    logic sdata;
    modport host (output frame_sel_n, output sclk, output sdata);
    modport device (input frame_sel_n, input sclk, input sdata);
endinterface

// ---- src/sdfpm_device.sv ----
// Purpose: converter end, shifts frames and holds code and power mode
// Assumes: link wires are asynchronous, sampled on i_ref_clk
// Notes: link clock must stay well under a quarter of i_ref_clk
//
// How it works
// - frame select low arms the shift register
// - sample data on each falling shift edge
// - sixteenth edge loads code and mode
// - first two bits select power mode
// - eight code bits follow, rest ignored
// - host sends most significant bit first
// - host keeps select high well past 20 ns between frames
// - early select rise clears partial frame
// - aborted frame changes neither code nor mode
// - power-up clears code to zero
// - zero held until first valid frame
// - mode bits decode to amplifier on, 1k, 100k or high-Z
// - power-down switches output to 1k, 100k or high-Z
// - power-down keeps code register intact
// - output valid after 50 us wake from power-down, and at once after reset
// - code is straight binary 0 to 255
`timescale 1ns/10ps
`include "sdfpm_params.svh"
module sdfpm_device
    import sdfpm_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    sdfpm_if.device link,
    output logic [7:0] o_code,
    output sdfpm_mode_t o_mode,
    output logic o_amp_on,
    output logic o_term_1k,
    output logic o_term_100k,
    output logic o_out_valid,
    output logic o_frame_done
);
    typedef enum logic [1:0] {SDFPM_IDLE, SDFPM_SHIFT, SDFPM_DONE} sdfpm_fsm_t;

    logic [2:0] sel_sync;
    logic [2:0] clk_sync;
    logic [2:0] dat_sync;
    logic sel_n;
    logic sclk_q;
    logic dat_q;
    logic [15:0] shreg;
    logic [4:0] bit_cnt;
    sdfpm_fsm_t state;
    logic [15:0] wake_cnt;
    logic fall;
    logic [15:0] next_shreg;

    ////////////////////////////////////////////////////////////////
    // three-stage sampling; a change counts once stages 2 and 3 agree
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sel_sync <= 3'h7;
            clk_sync <= 3'h0;
            dat_sync <= 3'h0;
        end else begin
            sel_sync <= {sel_sync[1:0], link.frame_sel_n};
            clk_sync <= {clk_sync[1:0], link.sclk};
            dat_sync <= {dat_sync[1:0], link.sdata};
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sel_n <= 1'b1;
            sclk_q <= 1'b0;
            dat_q <= 1'b0;
        end else begin
            if (sel_sync[1] == sel_sync[2]) sel_n <= sel_sync[2];
            if (clk_sync[1] == clk_sync[2]) sclk_q <= clk_sync[2];
            if (dat_sync[1] == dat_sync[2]) dat_q <= dat_sync[2];
        end
    end

    // data was settled before the clock edge, so the held data is safe to take
    assign fall = sclk_q && (clk_sync[1] == clk_sync[2]) && !clk_sync[2];
    assign next_shreg = {shreg[14:0], dat_q};

    ////////////////////////////////////////////////////////////////
    // frame sequencer
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= SDFPM_IDLE;
            shreg <= 16'h0000;
            bit_cnt <= 5'h00;
            o_frame_done <= 1'b0;
        end else begin
            o_frame_done <= 1'b0;
            case (state)
                SDFPM_IDLE: begin
                    shreg <= 16'h0000;
                    bit_cnt <= 5'h00;
                    if (!sel_n) state <= SDFPM_SHIFT;
                end
                SDFPM_SHIFT: begin
                    if (sel_n) begin
                        state <= SDFPM_IDLE;
                        shreg <= 16'h0000;
                    end else if (fall) begin
                        shreg <= next_shreg;
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == 5'(`SDFPM_FRAME_BITS - 1)) begin
                            state <= SDFPM_DONE;
                            o_frame_done <= 1'b1;
                        end
                    end
                end
                SDFPM_DONE: begin
                    if (sel_n) state <= SDFPM_IDLE;
                end
                default: state <= SDFPM_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // code and mode registers, loaded only by a complete frame
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_code <= `SDFPM_CODE_RESET;
            o_mode <= sdfpm_mode_t'(`SDFPM_MODE_RESET);
        end else if (o_frame_done) begin
            o_mode <= sdfpm_mode_t'(shreg[`SDFPM_MODE_MSB:`SDFPM_MODE_LSB]);
            o_code <= shreg[`SDFPM_CODE_MSB:`SDFPM_CODE_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////
    // output stage controls; code is untouched by power-down
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_amp_on <= 1'b1;
            o_term_1k <= 1'b0;
            o_term_100k <= 1'b0;
        end else begin
            o_amp_on <= (o_mode == SDFPM_NORMAL);
            o_term_1k <= (o_mode == SDFPM_GND_1K);
            o_term_100k <= (o_mode == SDFPM_GND_100K);
        end
    end

    // wake timer restarts on every power-down; reset counts as awake
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wake_cnt <= 16'h0000;
            o_out_valid <= 1'b1;
        end else if (o_mode != SDFPM_NORMAL) begin
            wake_cnt <= 16'h0000;
            o_out_valid <= 1'b0;
        end else if (!o_out_valid) begin
            wake_cnt <= wake_cnt + 16'h0001;
            if (wake_cnt == 16'(`SDFPM_WAKE_CYC - 1)) o_out_valid <= 1'b1;
        end
    end
endmodule // sdfpm_device

// ---- src/sdfpm_host.sv ----
// Purpose: host end, sends one 16-bit frame per request
// Assumes: shift clock made by dividing i_ref_clk
// Notes: requests while busy are ignored
`timescale 1ns/10ps
`include "sdfpm_params.svh"
module sdfpm_host
    import sdfpm_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_req,
    input wire logic [1:0] i_mode,
    input wire logic [7:0] i_code,
    input wire logic [4:0] i_abort_after,
    sdfpm_if.host link,
    output logic o_busy
);
    typedef enum logic [1:0] {SDFPM_H_IDLE, SDFPM_H_SEND, SDFPM_H_GAP} sdfpm_hfsm_t;

    sdfpm_hfsm_t state;
    logic [15:0] frame;
    logic [4:0] sent;
    logic [4:0] limit;
    logic [3:0] div;
    logic half;

    assign half = (div == 4'(`SDFPM_SCLK_HALF - 1));

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            div <= 4'h0;
        end else if (state != SDFPM_H_SEND || half) begin
            div <= 4'h0;
        end else begin
            div <= div + 4'h1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= SDFPM_H_IDLE;
            frame <= 16'h0000;
            sent <= 5'h00;
            limit <= 5'h10;
            link.frame_sel_n <= 1'b1;
            link.sclk <= 1'b0;
            link.sdata <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            case (state)
                SDFPM_H_IDLE: begin
                    if (i_req) begin
                        // abort count of 0 or above 16 sends a full frame
                        // first bit goes out now so it is settled before the first fall
                        link.sdata <= i_mode[1];
                        frame <= {i_mode[0], i_code, 7'h00};
                        limit <= (i_abort_after == 5'h00 || i_abort_after > 5'h10) ?
                            5'h10 : i_abort_after;
                        sent <= 5'h00;
                        link.frame_sel_n <= 1'b0;
                        link.sclk <= 1'b1;
                        o_busy <= 1'b1;
                        state <= SDFPM_H_SEND;
                    end
                end
                SDFPM_H_SEND: begin
                    if (half) begin
                        if (link.sclk) begin
                            link.sclk <= 1'b0;
                            sent <= sent + 5'h01;
                        end else if (sent == limit) begin
                            link.frame_sel_n <= 1'b1;
                            state <= SDFPM_H_GAP;
                            sent <= 5'h00;
                        end else begin
                            // data changes on the rise, a half period before the sampling fall
                            link.sclk <= 1'b1;
                            link.sdata <= frame[15];
                            frame <= {frame[14:0], 1'b0};
                        end
                    end
                end
                SDFPM_H_GAP: begin
                    // hold select high well past 20 ns so the device sees it
                    sent <= sent + 5'h01;
                    if (sent == 5'(`SDFPM_SEL_HIGH_CYC + 8)) begin
                        o_busy <= 1'b0;
                        state <= SDFPM_H_IDLE;
                    end
                end
                default: state <= SDFPM_H_IDLE;
            endcase
        end
    end
endmodule // sdfpm_host

// ---- verification/sdfpm_properties.sv ----
// Purpose: link timing and output relations of both ends
// Assumes: one clock domain, i_resetn async low
// Notes: watches the joined link and device outputs
`timescale 1ns/10ps
`include "sdfpm_params.svh"
module sdfpm_properties
    import sdfpm_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic frame_sel_n,
    input wire logic sclk,
    input wire logic [7:0] o_code,
    input wire sdfpm_mode_t o_mode,
    input wire logic o_amp_on,
    input wire logic o_term_1k,
    input wire logic o_term_100k,
    input wire logic o_out_valid,
    input wire logic o_frame_done
);
    localparam int WAKE_LO = `SDFPM_WAKE_CYC - 8;
    localparam int WAKE_HI = `SDFPM_WAKE_CYC + 8;
    int unsigned run;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////////////////////////////////////////
    // cycles spent in normal mode, for the wake window
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            run <= 0;
        end else begin
            run <= (o_mode == SDFPM_NORMAL) ? run + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    sel_gap_a: assert property ($rose(frame_sel_n) |-> frame_sel_n[*3])
        else $error("select high too short");
    sclk_low_a: assert property ($fell(sclk) |-> !sclk[*4])
        else $error("shift clock low too short");
    sclk_high_a: assert property ($rose(sclk) |-> sclk[*4])
        else $error("shift clock high too short");
    done_sel_a: assert property (o_frame_done |-> !frame_sel_n)
        else $error("frame done outside a frame");
    done_pulse_a: assert property (o_frame_done |=> !o_frame_done)
        else $error("frame done longer than one cycle");
    code_hold_a: assert property ($changed(o_code) |-> $past(o_frame_done))
        else $error("code changed without a frame");
    mode_hold_a: assert property ($changed(o_mode) |-> $past(o_frame_done))
        else $error("mode changed without a frame");
    amp_mode_a: assert property (o_amp_on == ($past(o_mode) == SDFPM_NORMAL))
        else $error("amplifier does not follow mode");
    term_mode_a: assert property ({o_term_1k, o_term_100k} ==
        {$past(o_mode) == SDFPM_GND_1K, $past(o_mode) == SDFPM_GND_100K})
        else $error("termination does not follow mode");
    pd_valid_a: assert property ((o_mode != SDFPM_NORMAL)[*2] |-> !o_out_valid)
        else $error("output valid in power-down");
    wake_a: assert property ($rose(o_out_valid) |-> run >= WAKE_LO && run <= WAKE_HI)
        else $error("wake delay out of window");
    cover property (o_frame_done);
    cover property (o_mode == SDFPM_HIGH_Z);
    cover property ($rose(o_out_valid));
endmodule // sdfpm_properties

// ---- verification/tb_serial_dac_frame_and_power_mode.sv ----
// Purpose: host and device ends joined, frames checked at outputs
// Assumes: host makes its own shift clock
// Notes: abort cases use the host abort count
`timescale 1ns/10ps
module tb_serial_dac_frame_and_power_mode;
    import sdfpm_pkg::*;
    typedef struct packed {
        logic [1:0] mode;
        logic [7:0] code;
        logic [4:0] abort;
        logic [7:0] exp_code;
        logic [1:0] exp_mode;
    } sdfpm_row_t;
    // first row aborts before any full frame, so zero must hold
    sdfpm_row_t rows [8] = '{'{2'h0, 8'hff, 5'h08, 8'h00, 2'h0},
        '{2'h0, 8'ha5, 5'h00, 8'ha5, 2'h0}, '{2'h0, 8'h5a, 5'h0f, 8'ha5, 2'h0},
        '{2'h1, 8'hff, 5'h00, 8'hff, 2'h1}, '{2'h2, 8'h00, 5'h10, 8'h00, 2'h2},
        '{2'h3, 8'h81, 5'h01, 8'h00, 2'h2}, '{2'h3, 8'h81, 5'h00, 8'h81, 2'h3},
        '{2'h0, 8'h3c, 5'h00, 8'h3c, 2'h0}};
    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_req = 1'b0;
    logic [1:0] i_mode = 2'h0;
    logic [7:0] i_code = 8'h00;
    logic [4:0] i_abort_after = 5'h00;
    logic o_busy, o_amp_on, o_term_1k, o_term_100k, o_out_valid, o_frame_done;
    logic [7:0] o_code;
    sdfpm_mode_t o_mode;
    int num_errors = 0;
    int checked = 0;
    int dones = 0;
    int d0;
    sdfpm_if link();
    sdfpm_host i_sdfpm_host(.i_ref_clk, .i_resetn, .i_req, .i_mode, .i_code,
        .i_abort_after, .link(link.host), .o_busy);
    sdfpm_device i_sdfpm_device(.i_ref_clk, .i_resetn, .link(link.device), .o_code,
        .o_mode, .o_amp_on, .o_term_1k, .o_term_100k, .o_out_valid, .o_frame_done);
    sdfpm_properties i_sdfpm_properties(.i_ref_clk, .i_resetn,
        .frame_sel_n(link.frame_sel_n), .sclk(link.sclk), .o_code, .o_mode,
        .o_amp_on, .o_term_1k, .o_term_100k, .o_out_valid, .o_frame_done);
    always #4 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        if (o_frame_done === 1'b1) begin
            dones <= dones + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic send(input logic [1:0] m, input logic [7:0] c, input logic [4:0] ab);
        int n;
        @(posedge i_ref_clk);
        i_mode <= m;
        i_code <= c;
        i_abort_after <= ab;
        i_req <= 1'b1;
        @(posedge i_ref_clk);
        i_req <= 1'b0;
        n = 0;
        @(negedge i_ref_clk);
        while (o_busy !== 1'b0 && n < 1000) begin
            @(negedge i_ref_clk);
            n++;
        end
        if (n >= 1000) begin
            num_errors++;
        end
    endtask
    function automatic logic [2:0] term_of(input logic [1:0] m);
        return {m == 2'h0, m == 2'h1, m == 2'h2};
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // a run of ten frames plus one wake takes near 70 us
    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        @(negedge i_ref_clk);
        check(16'(o_code), 16'h0000);
        check(16'(o_out_valid), 16'h0001);
        foreach (rows[k]) begin
            d0 = dones;
            send(rows[k].mode, rows[k].code, rows[k].abort);
            check(16'(o_code), 16'(rows[k].exp_code));
            check(16'(o_mode), 16'(rows[k].exp_mode));
            check(16'({o_amp_on, o_term_1k, o_term_100k}), 16'(term_of(rows[k].exp_mode)));
            check(16'(dones - d0), (rows[k].abort inside {[1:15]}) ? 16'h0 : 16'h1);
        end
        check(16'(o_out_valid), 16'h0000);
        repeat (6300) @(negedge i_ref_clk);
        check(16'(o_out_valid), 16'h0001);
        send(2'h1, 8'h77, 5'h00);
        @(posedge i_ref_clk);
        i_resetn <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        @(negedge i_ref_clk);
        check(16'({o_code, 6'h00, o_mode}), 16'h0000);
        send(2'h0, 8'hc3, 5'h00);
        check(16'(o_code), 16'h00c3);
        print_verdict();
    end
endmodule // tb_serial_dac_frame_and_power_mode
